// File: pts_regs.vh
`ifndef PTS_REGS_VH
`define PTS_REGS_VH
// ----------------------------------------------------------------
// table layout and limits
// ----------------------------------------------------------------
`define PTS_ENTRIES 255
`define PTS_POS_MAX 24'h0F_423F
`define PTS_TIME_MAX_MS 15'h4E20
`define PTS_CODE_MAX 7'h63
`define PTS_CLK_HZ 50000000
`define PTS_CYC_PER_MS (`PTS_CLK_HZ / 1000)
// entry word field positions (lsb)
`define PTS_F_POS 0
`define PTS_F_SPD 24
`define PTS_F_ACC 40
`define PTS_F_DEC 55
`define PTS_F_DWL 70
`define PTS_F_AUX 85
`define PTS_F_MCD 87
`define PTS_ENTRY_W 94
`endif

// File: pts_mem.v
`default_nettype none
// ----------------------------------------------------------------
// point table storage, registered read
// ----------------------------------------------------------------
module pts_mem #(
  parameter W = 94,
  parameter AW = 8
) (
  input wire clk_i, // clock
  input wire we_i, // write strobe
  input wire [AW-1:0] waddr_i, // write index
  input wire [W-1:0] wdata_i, // write word
  input wire [AW-1:0] raddr_i, // read index
  output reg [W-1:0] rdata_o // read word, one cycle late
);
  reg [W-1:0] mem [0:(1<<AW)-1];
  // no reset: contents are loaded by the host before use
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule // pts_mem
`default_nettype wire

// File: pts_sequencer.v
`include "pts_regs.vh"
`default_nettype none
module pts_sequencer #(
  parameter ENTRIES = `PTS_ENTRIES,
  parameter CYC_PER_MS = `PTS_CYC_PER_MS
) (
  input wire core_clk_i, // 50 MHz clock
  input wire arst_n_i, // async reset, active low
  input wire tbl_we_i, // table write strobe
  input wire [7:0] tbl_waddr_i, // table write entry number
  input wire [93:0] tbl_wdata_i, // table write entry word
  input wire incr_method_i, // 1 = incremental command method
  input wire [2:0] position_scale_exponent_i, // scale exponent
  input wire [7:0] start_entry_i, // entry chosen by host, 1..255
  input wire start_i, // start pulse from host
  input wire move_done_i, // profile generator reports arrival
  input wire [3:0] scurve_param_i, // amplifier-wide s-curve setting
  output reg move_req_o, // one-cycle move request
  output reg move_incr_o, // move is relative
  output reg signed [47:0] move_pos_o, // scaled position, um
  output reg [15:0] move_speed_o, // commanded speed, r/min
  output reg [14:0] move_acc_ms_o, // acceleration time constant
  output reg [14:0] move_dec_ms_o, // deceleration time constant
  output reg [3:0] move_scurve_o, // s-curve shaping for the move
  output reg [6:0] ext_mcode_o, // completion code on extension outputs
  output reg ext_mcode_valid_o, // completion code valid
  output reg busy_o, // sequence running
  output reg range_err_o, // entry data out of range, sticky until start
  output reg [7:0] cur_entry_o // entry in progress
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  reg rst_s1;
  reg rst_n;
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // ----------------------------------------------------------------
  // table memory
  // ----------------------------------------------------------------
  localparam ST_IDLE = 3'd0;
  localparam ST_READ = 3'd1;
  localparam ST_LOAD = 3'd2;
  localparam ST_MOVE = 3'd3;
  localparam ST_DWELL = 3'd4;
  reg [2:0] state;
  reg [7:0] entry;
  wire [93:0] rd;
  // writes to entry 0 are dropped: only 1..255 are selectable
  pts_mem #(.W(`PTS_ENTRY_W), .AW(8)) u_mem (
    .clk_i(core_clk_i),
    .we_i(tbl_we_i && tbl_waddr_i != 8'h00),
    .waddr_i(tbl_waddr_i),
    .wdata_i(tbl_wdata_i),
    .raddr_i(entry),
    .rdata_o(rd)
  );

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire signed [23:0] f_pos = rd[`PTS_F_POS +: 24];
  wire [15:0] f_spd = rd[`PTS_F_SPD +: 16];
  wire [14:0] f_acc = rd[`PTS_F_ACC +: 15];
  wire [14:0] f_dec = rd[`PTS_F_DEC +: 15];
  wire [14:0] f_dwl = rd[`PTS_F_DWL +: 15];
  wire [1:0] f_aux = rd[`PTS_F_AUX +: 2];
  wire [6:0] f_mcd = rd[`PTS_F_MCD +: 7];
  // incremental method forces relative moves; absolute uses aux bit 1
  wire is_incr = incr_method_i | f_aux[1];
  wire chain = f_aux[0];
  wire aux_bad = incr_method_i & f_aux[1];

  // ----------------------------------------------------------------
  // range checks
  // ----------------------------------------------------------------
  // refused entries raise range_err_o and never reach the profile generator
  wire [23:0] pos_mag = f_pos[23] ? (24'h00_0000 - f_pos) : f_pos;
  wire pos_bad = (pos_mag > `PTS_POS_MAX) || (incr_method_i && f_pos[23]);
  // each time is checked on its own, so a bad dwell is caught before the move starts
  wire acc_bad = f_acc > `PTS_TIME_MAX_MS;
  wire dec_bad = f_dec > `PTS_TIME_MAX_MS;
  wire dwl_bad = f_dwl > `PTS_TIME_MAX_MS;
  wire tim_bad = acc_bad || dec_bad || dwl_bad;
  wire code_bad = f_mcd > `PTS_CODE_MAX;

  // power-of-ten scale, exponent clipped to 5
  reg [19:0] scale;
  always @* begin
    case (position_scale_exponent_i)
      3'd0: scale = 20'h0_0001;
      3'd1: scale = 20'h0_000A;
      3'd2: scale = 20'h0_0064;
      3'd3: scale = 20'h0_03E8;
      3'd4: scale = 20'h0_2710;
      default: scale = 20'h1_86A0;
    endcase
  end
  wire signed [44:0] pos_scaled = f_pos * $signed({1'b0, scale});

  // ----------------------------------------------------------------
  // dwell timer: ms prescaler plus ms counter
  // ----------------------------------------------------------------
  reg [15:0] pre;
  reg [14:0] dwell_left;
  // compare at full parameter width so a large CYC_PER_MS is never cut silently
  wire [31:0] pre_w = {16'h0000, pre};
  wire ms_tick = (pre_w == CYC_PER_MS - 1);
  wire [31:0] entry_w = {24'h00_0000, entry};
  // the last entry never chains: entry + 1 would wrap to the unused slot 0
  wire last_entry = (entry_w == ENTRIES);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      entry <= 8'h00;
      pre <= 16'h0000;
      dwell_left <= 15'h0000;
      move_req_o <= 1'b0;
      move_incr_o <= 1'b0;
      move_pos_o <= 48'h0000_0000_0000;
      move_speed_o <= 16'h0000;
      move_acc_ms_o <= 15'h0000;
      move_dec_ms_o <= 15'h0000;
      move_scurve_o <= 4'h0;
      ext_mcode_o <= 7'h00;
      ext_mcode_valid_o <= 1'b0;
      busy_o <= 1'b0;
      range_err_o <= 1'b0;
      cur_entry_o <= 8'h00;
    end else begin
      move_req_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          // a stopped entry only resumes on a fresh start
          // starts that arrive while busy are not looked at outside this state
          if (start_i && start_entry_i != 8'h00) begin
            entry <= start_entry_i;
            range_err_o <= 1'b0;
            ext_mcode_valid_o <= 1'b0;
            busy_o <= 1'b1;
            state <= ST_READ;
          end
        end
        ST_READ: begin
          state <= ST_LOAD; // memory read latency
        end
        ST_LOAD: begin
          if (pos_bad || tim_bad || code_bad || aux_bad) begin
            range_err_o <= 1'b1;
            busy_o <= 1'b0;
            state <= ST_IDLE;
          end else begin
            move_incr_o <= is_incr;
            move_pos_o <= {{3{pos_scaled[44]}}, pos_scaled};
            move_speed_o <= f_spd;
            move_acc_ms_o <= f_acc;
            move_dec_ms_o <= f_dec;
            move_scurve_o <= scurve_param_i;
            move_req_o <= 1'b1;
            cur_entry_o <= entry;
            ext_mcode_valid_o <= 1'b0;
            state <= ST_MOVE;
          end
        end
        ST_MOVE: begin
          if (move_done_i) begin
            // code goes only to the extension outputs
            ext_mcode_o <= f_mcd;
            ext_mcode_valid_o <= 1'b1;
            dwell_left <= f_dwl;
            pre <= 16'h0000;
            state <= ST_DWELL;
          end
        end
        ST_DWELL: begin
          pre <= ms_tick ? 16'h0000 : pre + 16'h0001;
          if (dwell_left == 15'h0000) begin
            if (chain && !last_entry) begin
              entry <= entry + 8'h01;
              state <= ST_READ;
            end else begin
              busy_o <= 1'b0;
              state <= ST_IDLE;
            end
          end else if (ms_tick) begin
            dwell_left <= dwell_left - 15'h0001;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // pts_sequencer
`default_nettype wire

// File: pts_host_model.sv
`default_nettype none
module pts_host (
  input wire logic clk_i, // clock
  input wire logic move_req_i, // request seen
  output logic start_o, // start pulse
  output logic [7:0] entry_o, // entry
  output logic done_o // arrival
);
  timeunit 1ns;
  timeprecision 1ps;
  int lat = 4; // arrival delay
  int cnt = -1;
  initial begin
    start_o = 0;
    entry_o = 0;
    done_o = 0;
  end
  // one-cycle start; entry scrambled after so a late read shows
  task go(input logic [7:0] e);
    @(negedge clk_i);
    start_o = 1;
    entry_o = e;
    @(negedge clk_i);
    start_o = 0;
    entry_o = ~e;
  endtask
  // profile stand-in reports arrival lat + 1 falling edges after the edge that sees each request
  always @(negedge clk_i) begin
    done_o <= cnt == 0;
    if (move_req_i) begin
      cnt <= lat;
    end else if (cnt >= 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule // pts_host
`default_nettype wire

// File: pts_sequencer_assertions.sv
`default_nettype none
module pts_chk (
  input wire logic core_clk_i, // clk
  input wire logic arst_n_i, // rst
  input wire logic start_i, // start
  input wire logic [7:0] start_entry_i, // entry
  input wire logic move_done_i, // done
  input wire logic [3:0] scurve_param_i, // s-curve
  input wire logic move_req_o, // req
  input wire logic signed [47:0] move_pos_o, // pos
  input wire logic [3:0] move_scurve_o, // s-curve
  input wire logic [6:0] ext_mcode_o, // code
  input wire logic ext_mcode_valid_o, // valid
  input wire logic busy_o, // busy
  input wire logic range_err_o, // error
  input wire logic [7:0] cur_entry_o // entry
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_go; start_i && !busy_o && start_entry_i != 8'h00; endsequence
  sequence s_ans; ##3 (move_req_o || range_err_o); endsequence
  property p_start; s_go |-> s_ans; endproperty
  a_start: assert property (p_start) else $error("start not answered");
  property p_pulse; move_req_o |=> !move_req_o; endproperty
  a_pulse: assert property (p_pulse) else $error("request too long");
  property p_busy; move_req_o |-> busy_o && !range_err_o && cur_entry_o != 8'h00; endproperty
  a_busy: assert property (p_busy) else $error("request while idle");
  property p_done; move_done_i && busy_o && !ext_mcode_valid_o |=> ext_mcode_valid_o; endproperty
  a_done: assert property (p_done) else $error("code not shown");
  property p_code; $rose(ext_mcode_valid_o) |-> ext_mcode_o <= 7'h63 && $past(move_done_i); endproperty
  a_code: assert property (p_code) else $error("bad code");
  property p_hold; !move_req_o |-> $stable({move_pos_o, move_scurve_o}); endproperty
  a_hold: assert property (p_hold) else $error("move fields moved");
  property p_scv; move_req_o |-> move_scurve_o == $past(scurve_param_i); endproperty
  a_scv: assert property (p_scv) else $error("s-curve not copied");
  property p_err; $rose(range_err_o) |-> !busy_o && !move_req_o; endproperty
  a_err: assert property (p_err) else $error("refused entry still moving");
  // no early chain; the wait is bounded by the short sim dwell
  property p_dwell; $rose(ext_mcode_valid_o) |-> (!move_req_o)[*3] ##[0:600] (move_req_o || !busy_o); endproperty
  a_dwell: assert property (p_dwell) else $error("dwell wrong");
endmodule // pts_chk
bind pts_sequencer pts_chk u_chk (
  .core_clk_i(core_clk_i),
  .arst_n_i(arst_n_i),
  .start_i(start_i),
  .start_entry_i(start_entry_i),
  .move_done_i(move_done_i),
  .scurve_param_i(scurve_param_i),
  .move_req_o(move_req_o),
  .move_pos_o(move_pos_o),
  .move_scurve_o(move_scurve_o),
  .ext_mcode_o(ext_mcode_o),
  .ext_mcode_valid_o(ext_mcode_valid_o),
  .busy_o(busy_o),
  .range_err_o(range_err_o),
  .cur_entry_o(cur_entry_o)
);
`default_nettype wire

// File: testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, we = 0, incr = 0, start, done, req, m_inc, mv, busy, rerr;
  logic [7:0] wa = 0, entry, cur;
  logic [93:0] wd = 0;
  logic [2:0] sc = 0;
  logic [3:0] scv = 4'h5, scurve;
  logic signed [47:0] pos;
  logic [15:0] spd;
  logic [14:0] acc, dec;
  logic [6:0] mc;
  longint scl;
  int err_count = 0, check_count = 0, cyc = 0;
  initial forever #10 clk = ~clk;
  // ms prescale shortened so dwell times fit a short run
  localparam int CPM = 10;
  pts_sequencer #(.CYC_PER_MS(CPM)) u_pts_sequencer (.core_clk_i(clk), .arst_n_i(rst_n), .tbl_we_i(we),
    .tbl_waddr_i(wa), .tbl_wdata_i(wd), .incr_method_i(incr), .position_scale_exponent_i(sc),
    .start_entry_i(entry), .start_i(start), .move_done_i(done), .scurve_param_i(scv), .move_req_o(req),
    .move_incr_o(m_inc), .move_pos_o(pos), .move_speed_o(spd), .move_acc_ms_o(acc), .move_dec_ms_o(dec),
    .move_scurve_o(scurve), .ext_mcode_o(mc), .ext_mcode_valid_o(mv), .busy_o(busy), .range_err_o(rerr),
    .cur_entry_o(cur));
  pts_host u_pts_host (.clk_i(clk), .move_req_i(req), .start_o(start), .entry_o(entry), .done_o(done));
  task chk(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      err_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  // speed, acceleration and deceleration times derive from the entry number
  task wr(input logic [7:0] n, input int p, input logic [1:0] aux, input logic [6:0] m, input logic [14:0] dw);
    @(negedge clk); we = 1; wa = n;
    wd = {m, aux, dw, 15'(n * 20), 15'(n * 10), 16'(n * 100), 24'(p)};
    @(negedge clk); we = 0;
  endtask
  // wt: expected falling edges from the previous completion to this request, -1 to skip
  task mv_exp(input logic [7:0] n, input int p, input logic inc, input logic [6:0] m, input int wt);
    int k;
    k = 0;
    while (req !== 1'b1 && k < 800) begin
      @(negedge clk);
      k++;
    end
    chk(req === 1'b1, "no move request");
    if (wt >= 0) chk(k == wt, "chain spacing");
    chk(cur === n && pos === 48'(longint'(p) * scl) && m_inc === inc, "target");
    chk(spd === 16'(n * 100) && acc === 15'(n * 10) && dec === 15'(n * 20), "profile");
    chk(scurve === scv, "s-curve");
    k = 0;
    while (mv !== 1'b1 && k < 900) begin
      @(negedge clk);
      k++;
    end
    chk(mv === 1'b1 && mc === m, "completion code");
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard, well above the several hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize;
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1;
    sc = 3'h2;
    scl = 100;
    wr(1, -999999, 2'h1, 7'h01, 15'h0002);
    wr(2, 2000, 2'h3, 7'h02, 15'h0000);
    wr(3, 999999, 2'h2, 7'h63, 15'h0000);
    wr(4, 999999, 2'h1, 7'h00, 15'h0000);
    wr(5, 0, 2'h0, 7'h05, 15'h0001);
    wr(6, 7, 2'h2, 7'h06, 15'h0000);
    wr(7, -1, 2'h0, 7'h07, 15'h0000);
    wr(8, 1000000, 2'h0, 7'h08, 15'h0000);
    wr(9, 5, 2'h0, 7'h09, 15'h4E21);
    wr(10, 5, 2'h0, 7'h64, 15'h0000);
    wr(11, -3, 2'h0, 7'h0B, 15'h0000);
    u_pts_host.go(1);
    mv_exp(1, -999999, 0, 1, -1);
    mv_exp(2, 2000, 1, 2, 2 * CPM + 3);
    mv_exp(3, 999999, 1, 99, 3);
    repeat (3) @(negedge clk);
    chk(busy === 1'b0, "absolute stop");
    $display("absolute chain done");
    incr = 1;
    sc = 3'h5;
    scl = 100000;
    scv = 4'hA;
    u_pts_host.lat = 40;
    u_pts_host.go(4);
    // a second start while the first entry loads must be ignored
    u_pts_host.go(9);
    mv_exp(4, 999999, 1, 0, -1);
    mv_exp(5, 0, 1, 5, 3);
    // one ms of dwell: busy drops CPM + 1 edges after completion
    repeat (CPM) @(negedge clk);
    chk(busy === 1'b1, "dwell ended early");
    @(negedge clk);
    chk(busy === 1'b0 && rerr === 1'b0, "no stop after dwell");
    $display("incremental chain done");
    // out-of-range entries must be refused without a move
    for (int n = 6; n <= 10; n++) begin
      if (n == 8) incr = 0;
      u_pts_host.go(8'(n));
      repeat (3) @(negedge clk);
      chk(rerr === 1'b1 && busy === 1'b0 && req === 1'b0, "entry not refused");
    end
    $display("refusal done");
    // every exponent code, 6 and 7 clipped to 5
    for (int e = 0; e < 8; e++) begin
      sc = 3'(e);
      scl = 1;
      for (int j = 0; j < e && j < 5; j++) begin
        scl = scl * 10;
      end
      u_pts_host.go(11);
      mv_exp(11, -3, 0, 11, -1);
      repeat (2) @(negedge clk);
      chk(busy === 1'b0 && rerr === 1'b0, "scaled entry did not stop");
    end
    $display("scale sweep done");
    summarize;
  end
endmodule // testbench
`default_nettype wire
